// ---- dv/tb.sv ----
// self-checking bench for the calculation unit
`timescale 1ns/100ps

module tb;
    logic clock;
    logic rst_n;
    logic slow;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_ready;
    logic [31:0] xreg;
    uxcu_pkg::uxcu_flags_t flags;
    uxcu_pkg::uxcu_flags_t fm;   // flags model
    logic [31:0] xm;             // x register model
    logic [31:0] var_m [0:255];  // variable model
    logic [7:0] exp_q [$];       // expected reply bytes
    logic [7:0] pick [0:3] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    logic [15:0] lfsr;
    logic [15:0] r16;
    int bad_count;
    int num_checks;
    int cycles;

    uxcu_calc_unit dut(.clock(clock), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .xreg(xreg), .flags(flags));
    uxcu_host_model host(.clock(clock), .slow(slow), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_ready(rx_ready), .tx_ready(tx_ready));

    ////////////////////////////////////////////////////////////
    // clock and hang guard
    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // frame with byte sum appended
    function automatic uxcu_pkg::uxcu_cmd_t mk(input logic [7:0] a, i, t, b, input logic [31:0] v);
        logic [7:0] s;
        s = a + i + t + b + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        return {a, i, t, b, v, s};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one command: predict, send, then compare state
    task automatic run(input logic [7:0] a, i, t, b, input logic flip);
        uxcu_pkg::uxcu_cmd_t f;
        uxcu_pkg::uxcu_cmd_t rep;
        logic [31:0] d;
        logic [31:0] s;
        logic [31:0] r;
        logic [7:0] st;
        f = mk(a, i, t, b, {rnd(), rnd()});
        f.csum = f.csum ^ {7'h0, flip};
        d = (i == 8'h2B) ? var_m[b] : xm;
        s = (i == 8'h2B) ? xm : var_m[b];
        st = (a != 8'h01) ? 8'h00 : flip ? 8'h01 : (i != 8'h2B && i != 8'h2C) ? 8'h02 :
            (t > 8'h0B) ? 8'h03 : 8'h64;
        r = 32'h0;
        if (st == 8'h64)
        begin
            r = d;
            case (t)
                8'h00: r = d + s;
                8'h01: r = d - s;
                8'h02: r = d * s;
                8'h03: if (s != 0) r = $signed(d) / $signed(s);
                8'h04: if (s != 0) r = $signed(d) % $signed(s);
                8'h05: r = d & s;
                8'h06: r = d | s;
                8'h07: r = d ^ s;
                8'h08: r = ~s;
                8'h09: r = s;
                8'h0A: {r, s} = {s, d};
                default: fm = {d == s, $signed(d) > $signed(s), $signed(d) < $signed(s)};
            endcase
            if (i == 8'h2B)
                {var_m[b], xm} = {r, s};
            else
                {xm, var_m[b]} = {r, s};
        end
        rep = mk(8'h02, 8'h01, st, i, r);
        if (a == 8'h01)
            for (int k = 8; k >= 0; k--)
                exp_q.push_back(rep[k*8 +: 8]);
        host.send(f);
        repeat (3) @(posedge clock);
        while (rx_ready !== 1'b1 || exp_q.size() != 0)
            @(posedge clock);
        check("x register", xreg, xm);
        check("flags", {29'h0, flags}, {29'h0, fm});
    endtask

    ////////////////////////////////////////////////////////////
    // reply watcher
    always @(posedge clock)
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected reply", 32'h1, 32'h0);
            else
                check("reply byte", {24'h0, tx_byte}, {24'h0, exp_q.pop_front()});
        end

    ////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        lfsr = 16'h747B;
        rst_n = 1'b0;
        slow = 1'b0;
        xm = 32'h0;
        fm = '0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        check("reset x", xreg, 32'h0);
        run(8'h01, 8'h2B, 8'h09, 8'h00, 1'b0);
        run(8'h01, 8'h2B, 8'h08, 8'h01, 1'b0);
        run(8'h01, 8'h2C, 8'h01, 8'h01, 1'b0);
        run(8'h01, 8'h2B, 8'h09, 8'h02, 1'b0);
        run(8'h01, 8'h2B, 8'h08, 8'hFF, 1'b0);
        run(8'h01, 8'h2C, 8'h03, 8'h00, 1'b0);
        for (int t = 0; t < 12; t++)
        begin
            run(8'h01, 8'h2B, t[7:0], 8'h02, 1'b0);
            run(8'h01, 8'h2C, t[7:0], 8'h01, 1'b0);
        end
        run(8'h01, 8'h2B, 8'h00, 8'h00, 1'b1);
        run(8'h01, 8'h2A, 8'h01, 8'h1B, 1'b0);
        run(8'h01, 8'h2C, 8'h0C, 8'h00, 1'b0);
        run(8'h05, 8'h2B, 8'h09, 8'h00, 1'b0);
        for (int n = 0; n < 150; n++)
        begin
            r16 = rnd();
            slow <= r16[4];
            run(8'h01, r16[0] ? 8'h2B : 8'h2C, {4'h0, r16[11:8]} % 8'h0C, pick[r16[3:2]], 1'b0);
        end
        wrap_up();
    end
endmodule // tb

// ---- dv/uxcu_calc_unit_assertions.sv ----
// port checker for the calculation unit
`timescale 1ns/100ps

module uxcu_calc_unit_checker
(
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  rx_valid,
    input wire logic [7:0]            rx_byte,
    input wire logic                  rx_ready,
    input wire logic                  tx_valid,
    input wire logic [7:0]            tx_byte,
    input wire logic                  tx_ready,
    input wire logic [31:0]           xreg,
    input wire uxcu_pkg::uxcu_flags_t flags
);
    logic [3:0] rx_idx;       // command byte slot
    logic [3:0] tx_idx;       // reply byte slot
    logic [7:0] tx_sum;       // running reply sum
    logic       for_us;       // frame addressed here
    logic [3:0] next_rx_idx;
    logic [3:0] next_tx_idx;
    logic [7:0] next_tx_sum;
    logic       next_for_us;

    ////////////////////////////////////////////////////////////
    // frame position tracking
    always_comb
    begin
        next_rx_idx = rx_idx;
        next_tx_idx = tx_idx;
        next_tx_sum = tx_sum;
        next_for_us = for_us;
        // command byte taken
        if (rx_valid && rx_ready)
        begin
            next_rx_idx = (rx_idx == 4'h8) ? 4'h0 : rx_idx + 4'h1;
            if (rx_idx == 4'h0)
                next_for_us = (rx_byte == 8'h01);
        end
        // reply byte taken
        if (tx_valid && tx_ready)
        begin
            next_tx_idx = (tx_idx == 4'h8) ? 4'h0 : tx_idx + 4'h1;
            next_tx_sum = (tx_idx == 4'h8) ? 8'h00 : tx_sum + tx_byte;
        end
    end

    // registers only
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            {rx_idx, tx_idx, tx_sum, for_us} <= '0;
        else
            {rx_idx, tx_idx, tx_sum, for_us} <= {next_rx_idx, next_tx_idx, next_tx_sum, next_for_us};

    ////////////////////////////////////////////////////////////
    // steps of a transfer
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence cmd_end_s;
        rx_valid && rx_ready && rx_idx == 4'h8;
    endsequence

    sequence rep_end_s;
        tx_valid && tx_ready && tx_idx == 4'h8;
    endsequence

    rx_closed_a: assert property (cmd_end_s |=> !rx_ready)
        else $error("still ready after ninth command byte");
    reply_start_a: assert property (cmd_end_s ##0 for_us |-> ##[2:35] $rose(tx_valid))
        else $error("no reply after command frame");
    host_first_a: assert property (tx_valid && tx_idx == 4'h0 |-> tx_byte == 8'h02)
        else $error("reply does not open with host address");
    target_next_a: assert property (tx_valid && tx_idx == 4'h1 |-> tx_byte == 8'h01)
        else $error("second reply byte not target address");
    status_code_a: assert property (tx_valid && tx_idx == 4'h2 |-> tx_byte inside {8'h64, 8'h01, 8'h02, 8'h03})
        else $error("unknown status code");
    reply_sum_a: assert property (tx_valid && tx_idx == 4'h8 |-> tx_byte == tx_sum)
        else $error("reply checksum wrong");
    byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte moved before taken");
    reply_close_a: assert property (rep_end_s |=> !tx_valid ##[0:1] rx_ready)
        else $error("reply did not close");
    // a result lands on the edge that also raises tx_valid, so look one sample back
    xreg_quiet_a: assert property ($changed(xreg) |-> !rx_ready && !$past(tx_valid))
        else $error("x register moved outside execution");
    flags_quiet_a: assert property ($changed(flags) |-> !rx_ready && !$past(tx_valid))
        else $error("compare flags moved outside execution");
endmodule // uxcu_calc_unit_checker

bind uxcu_calc_unit uxcu_calc_unit_checker chk
(
    .clock    (clock),
    .rst_n    (rst_n),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .rx_ready (rx_ready),
    .tx_valid (tx_valid),
    .tx_byte  (tx_byte),
    .tx_ready (tx_ready),
    .xreg     (xreg),
    .flags    (flags)
);

// ---- dv/uxcu_host_model.sv ----
// host side model: sends command frames, takes replies
`timescale 1ns/100ps

module uxcu_host_model
(
    input  wire logic  clock,
    input  wire logic  slow,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    input  wire logic  rx_ready,
    output logic       tx_ready
);
    logic [1:0] tick; // stall pattern

    initial
    begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
        tick = 2'h0;
    end

    // takes reply bytes, one in four when slow
    always @(posedge clock)
    begin
        tick <= tick + 2'h1;
        tx_ready <= !slow || tick == 2'h3;
    end

    // nine bytes first to last, each held until taken
    task automatic send(input uxcu_pkg::uxcu_cmd_t f);
        logic [7:0] b;
        for (int k = 8; k >= 0; k--)
        begin
            b = f[k*8 +: 8];
            rx_valid <= 1'b1;
            rx_byte <= b;
            do @(posedge clock); while (rx_ready !== 1'b1);
            // idle gap shows a changed data line
            if (slow)
            begin
                rx_valid <= 1'b0;
                rx_byte <= ~b;
                @(posedge clock);
            end
        end
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
endmodule // uxcu_host_model

// ---- hw/uxcu_calc_unit.sv ----
// frame driven calculation unit on user variables and the x register
`timescale 1ns/100ps

module uxcu_calc_unit
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    output logic                      rx_ready,
    output logic                      tx_valid,
    output logic [7:0]                tx_byte,
    input  wire logic                 tx_ready,
    output logic [31:0]               xreg,
    output uxcu_pkg::uxcu_flags_t     flags
);

`include "uxcu_params.svh"

    ////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic                    rst_meta_n;  // first stage
    logic                    rst_sync_n;  // released copy

    // release through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0]             uvar [0:255];     // user variable store
    uxcu_pkg::uxcu_state_t   state, next_state;
    logic [3:0]              byte_cnt, next_byte_cnt;
    logic [71:0]             frame, next_frame;  // command shift reg
    logic [7:0]              sum, next_sum;      // running checksum
    logic                    csum_ok, next_csum_ok;
    logic [71:0]             reply, next_reply;  // reply shift reg
    logic                    next_rx_ready;
    logic                    next_tx_valid;
    logic [31:0]             next_xreg;
    uxcu_pkg::uxcu_flags_t   next_flags;
    logic [31:0]             dq, next_dq;        // quotient / dividend
    logic [32:0]             dr, next_dr;        // partial remainder
    logic [31:0]             db, next_db;        // divisor magnitude
    logic                    dnq, next_dnq;      // negate quotient
    logic                    dnr, next_dnr;      // negate remainder
    logic [5:0]              dcnt, next_dcnt;    // divider steps
    logic                    mem_we;             // variable write
    logic [31:0]             mem_wdata;

    // decoded command view
    uxcu_pkg::uxcu_cmd_t     cmd;
    logic                    is_vx;
    logic [31:0]             var_val;
    logic [31:0]             dst;
    logic [31:0]             src;
    logic [63:0]             prod;
    logic [32:0]             rtmp;
    logic [31:0]             quo;
    logic [31:0]             rem;

    assign cmd     = uxcu_pkg::uxcu_cmd_t'(frame);
    assign is_vx   = (cmd.instr == `UXCU_INSTR_VX);
    // value field never read as operand
    assign var_val = uvar[cmd.bank];
    // operand roles per instruction
    assign dst     = is_vx ? var_val : xreg;
    assign src     = is_vx ? xreg : var_val;
    assign prod    = dst * src;

    ////////////////////////////////////////////////////////////////////////
    // reply builder with checksum
    function automatic logic [71:0] mk_reply
    (
        input logic [7:0]  st,
        input logic [7:0]  ins,
        input logic [31:0] val
    );
        logic [7:0] cs;
        cs = `UXCU_HOST_ADDR + `UXCU_MODULE_ADDR + st + ins;
        cs = cs + val[31:24] + val[23:16] + val[15:8] + val[7:0];
        // host, module, status, instr, value msb first, sum
        mk_reply = {`UXCU_HOST_ADDR, `UXCU_MODULE_ADDR, st, ins, val, cs};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state logic
    always_comb
    begin
        next_state    = state;
        next_byte_cnt = byte_cnt;
        next_frame    = frame;
        next_sum      = sum;
        next_csum_ok  = csum_ok;
        next_reply    = reply;
        next_rx_ready = rx_ready;
        next_tx_valid = tx_valid;
        next_xreg     = xreg;
        next_flags    = flags;
        next_dq       = dq;
        next_dr       = dr;
        next_db       = db;
        next_dnq      = dnq;
        next_dnr      = dnr;
        next_dcnt     = dcnt;
        mem_we        = 1'b0;
        mem_wdata     = src;
        rtmp          = {dr[31:0], dq[31]};
        quo           = dnq ? (32'h0 - dq) : dq;
        rem           = dnr ? (32'h0 - dr[31:0]) : dr[31:0];
        case (state)
            // collect nine bytes, msb of value first
            uxcu_pkg::UXCU_S_RECV:
            begin
                if (rx_valid && rx_ready)
                begin
                    next_frame = {frame[63:0], rx_byte};
                    if (byte_cnt == `UXCU_LAST_BYTE)
                    begin
                        // last byte is the checksum
                        next_csum_ok  = (sum == rx_byte);
                        next_sum      = 8'h00;
                        next_byte_cnt = 4'h0;
                        next_rx_ready = 1'b0;
                        next_state    = uxcu_pkg::UXCU_S_EXEC;
                    end
                    else
                    begin
                        next_sum      = sum + rx_byte;
                        next_byte_cnt = byte_cnt + 4'h1;
                    end
                end
            end
            // decode and execute
            uxcu_pkg::UXCU_S_EXEC:
            begin
                next_state    = uxcu_pkg::UXCU_S_SEND;
                next_tx_valid = 1'b1;
                if (cmd.addr != `UXCU_MODULE_ADDR)
                begin
                    // other target: drop silently
                    next_state    = uxcu_pkg::UXCU_S_RECV;
                    next_tx_valid = 1'b0;
                    next_rx_ready = 1'b1;
                end
                else if (!csum_ok)
                    next_reply = mk_reply(`UXCU_ST_BAD_CSUM, cmd.instr, 32'h0);
                else if (!is_vx && cmd.instr != `UXCU_INSTR_XV)
                    next_reply = mk_reply(`UXCU_ST_BAD_CMD, cmd.instr, 32'h0);
                else if (cmd.op > `UXCU_OP_LAST)
                    next_reply = mk_reply(`UXCU_ST_BAD_TYPE, cmd.instr, 32'h0);
                else
                begin
                    // default answer: ok, destination unchanged
                    next_reply = mk_reply(`UXCU_ST_OK, cmd.instr, dst);
                    case (cmd.op)
                        // arithmetic
                        uxcu_pkg::UXCU_OP_ADD:  mem_wdata = dst + src;
                        uxcu_pkg::UXCU_OP_SUB:  mem_wdata = dst - src;
                        uxcu_pkg::UXCU_OP_MUL:  mem_wdata = prod[31:0];
                        // logic and load
                        uxcu_pkg::UXCU_OP_AND:  mem_wdata = dst & src;
                        uxcu_pkg::UXCU_OP_OR:   mem_wdata = dst | src;
                        uxcu_pkg::UXCU_OP_XOR:  mem_wdata = dst ^ src;
                        uxcu_pkg::UXCU_OP_NOT:  mem_wdata = ~src;
                        uxcu_pkg::UXCU_OP_LOAD: mem_wdata = src;
                        // destination takes source, other side below
                        uxcu_pkg::UXCU_OP_SWAP: mem_wdata = src;
                        default:                mem_wdata = dst;
                    endcase
                    if (cmd.op == uxcu_pkg::UXCU_OP_COMP)
                    begin
                        // flags only, operands untouched
                        next_flags.eq = (dst == src);
                        next_flags.gt = ($signed(dst) > $signed(src));
                        next_flags.lt = ($signed(dst) < $signed(src));
                    end
                    else if (cmd.op == uxcu_pkg::UXCU_OP_DIV || cmd.op == uxcu_pkg::UXCU_OP_MOD)
                    begin
                        // signed iterative division, zero divisor leaves dst
                        if (src != 32'h0)
                        begin
                            next_tx_valid = 1'b0;
                            next_state    = uxcu_pkg::UXCU_S_DIV;
                            next_dq       = dst[31] ? (32'h0 - dst) : dst;
                            next_db       = src[31] ? (32'h0 - src) : src;
                            next_dr       = 33'h0;
                            next_dnq      = dst[31] ^ src[31];
                            next_dnr      = dst[31];
                            next_dcnt     = 6'h0;
                        end
                    end
                    else
                    begin
                        // write back to the destination
                        next_reply = mk_reply(`UXCU_ST_OK, cmd.instr, mem_wdata);
                        mem_we     = is_vx;
                        if (!is_vx)
                            next_xreg = mem_wdata;
                        if (cmd.op == uxcu_pkg::UXCU_OP_SWAP)
                        begin
                            // source side takes old destination
                            if (is_vx)
                                next_xreg = dst;
                            else
                            begin
                                mem_we    = 1'b1;
                                mem_wdata = dst;
                            end
                        end
                    end
                end
            end
            // one quotient bit per cycle, then write back
            uxcu_pkg::UXCU_S_DIV:
            begin
                if (dcnt == `UXCU_DIV_STEPS)
                begin
                    mem_wdata     = (cmd.op == uxcu_pkg::UXCU_OP_DIV) ? quo : rem;
                    mem_we        = is_vx;
                    if (!is_vx)
                        next_xreg = mem_wdata;
                    next_reply    = mk_reply(`UXCU_ST_OK, cmd.instr, mem_wdata);
                    next_tx_valid = 1'b1;
                    next_state    = uxcu_pkg::UXCU_S_SEND;
                end
                else
                begin
                    next_dcnt = dcnt + 6'h1;
                    if (rtmp >= {1'b0, db})
                    begin
                        next_dr = rtmp - {1'b0, db};
                        next_dq = {dq[30:0], 1'b1};
                    end
                    else
                    begin
                        next_dr = rtmp;
                        next_dq = {dq[30:0], 1'b0};
                    end
                end
            end
            // shift reply out, host address first
            default:
            begin
                if (tx_ready)
                begin
                    next_reply = {reply[63:0], 8'h00};
                    if (byte_cnt == `UXCU_LAST_BYTE)
                    begin
                        next_byte_cnt = 4'h0;
                        next_tx_valid = 1'b0;
                        next_rx_ready = 1'b1;
                        next_state    = uxcu_pkg::UXCU_S_RECV;
                    end
                    else
                        next_byte_cnt = byte_cnt + 4'h1;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state    <= uxcu_pkg::UXCU_S_RECV;
            byte_cnt <= 4'h0;
            frame    <= 72'h0;
            sum      <= 8'h00;
            csum_ok  <= 1'b0;
            reply    <= `UXCU_REPLY_RST;
            rx_ready <= 1'b1;
            tx_valid <= 1'b0;
            xreg     <= `UXCU_XREG_RST;
            flags    <= 3'h0;
            dq       <= 32'h0;
            dr       <= 33'h0;
            db       <= 32'h0;
            dnq      <= 1'b0;
            dnr      <= 1'b0;
            dcnt     <= 6'h0;
        end
        else
        begin
            state    <= next_state;
            byte_cnt <= next_byte_cnt;
            frame    <= next_frame;
            sum      <= next_sum;
            csum_ok  <= next_csum_ok;
            reply    <= next_reply;
            rx_ready <= next_rx_ready;
            tx_valid <= next_tx_valid;
            xreg     <= next_xreg;
            flags    <= next_flags;
            dq       <= next_dq;
            dr       <= next_dr;
            db       <= next_db;
            dnq      <= next_dnq;
            dnr      <= next_dnr;
            dcnt     <= next_dcnt;
        end
    end

    // variable store write port
    always_ff @(posedge clock)
    begin
        if (mem_we)
            uvar[cmd.bank] <= mem_wdata;
    end

    // top byte of the reply register
    assign tx_byte = reply[71:64];

endmodule // uxcu_calc_unit

// ---- hw/uxcu_params.svh ----
// constants for the user variable / x register calculation unit
`ifndef UXCU_PARAMS_SVH
`define UXCU_PARAMS_SVH

// frame addressing
`define UXCU_MODULE_ADDR  8'h01
`define UXCU_HOST_ADDR    8'h02

// instruction codes
`define UXCU_INSTR_VX     8'h2B
`define UXCU_INSTR_XV     8'h2C

// reply status codes
`define UXCU_ST_OK        8'h64
`define UXCU_ST_BAD_CSUM  8'h01
`define UXCU_ST_BAD_CMD   8'h02
`define UXCU_ST_BAD_TYPE  8'h03

// highest operation code
`define UXCU_OP_LAST      8'h0B

// frame length, last byte index
`define UXCU_LAST_BYTE    4'h8

// divider steps
`define UXCU_DIV_STEPS    6'h20

// reset values
`define UXCU_XREG_RST     32'h0000_0000
`define UXCU_REPLY_RST    72'h0

`endif

// ---- hw/uxcu_pkg.sv ----
// types for the user variable / x register calculation unit
package uxcu_pkg;

    // sequencer states
    typedef enum logic [1:0]
    {
        UXCU_S_RECV = 2'b00,
        UXCU_S_EXEC = 2'b01,
        UXCU_S_DIV  = 2'b10,
        UXCU_S_SEND = 2'b11
    } uxcu_state_t;

    // operation codes of the type byte
    typedef enum logic [7:0]
    {
        UXCU_OP_ADD  = 8'h00,
        UXCU_OP_SUB  = 8'h01,
        UXCU_OP_MUL  = 8'h02,
        UXCU_OP_DIV  = 8'h03,
        UXCU_OP_MOD  = 8'h04,
        UXCU_OP_AND  = 8'h05,
        UXCU_OP_OR   = 8'h06,
        UXCU_OP_XOR  = 8'h07,
        UXCU_OP_NOT  = 8'h08,
        UXCU_OP_LOAD = 8'h09,
        UXCU_OP_SWAP = 8'h0A,
        UXCU_OP_COMP = 8'h0B
    } uxcu_op_t;

    // nine byte command frame, first byte on top
    typedef struct packed
    {
        logic [7:0]  addr;
        logic [7:0]  instr;
        logic [7:0]  op;
        logic [7:0]  bank;
        logic [31:0] value;
        logic [7:0]  csum;
    } uxcu_cmd_t;

    // compare outcome flags
    typedef struct packed
    {
        logic eq;
        logic gt;
        logic lt;
    } uxcu_flags_t;

endpackage
